// ---- host_csr_pkg.sv ----
// constants for the host csr block: register offsets, field layout, resets.
// assumes a 32-bit host register port on one 100 MHz clock.
package host_csr_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_ROM_PORT   = 8'h04;
    localparam logic [7:0] OFF_RETRY      = 8'h08;
    localparam logic [7:0] OFF_SWAP_VALUE = 8'h0c;
    localparam logic [7:0] OFF_EXPECTED   = 8'h10;
    localparam logic [7:0] OFF_LAUNCH     = 8'h14;

    // identity rom read port fields
    localparam int ROM_CLR_BIT   = 31;
    localparam int ROM_GO_BIT    = 25;
    localparam int ROM_DATA_LSB  = 16;
    localparam int ROM_ADDR_W    = 8;

    // retry limit fields
    localparam int PHYS_LIM_LSB = 11;
    localparam int PHYS_LIM_W   = 5;
    localparam int SWR_LIM_LSB  = 4;
    localparam int REQ_LIM_LSB  = 0;
    localparam int SMALL_LIM_W  = 4;

    // launch register fields
    localparam int DONE_BIT = 31;
    localparam int SEL_W    = 2;

    // resource reset values, on hardware or bus reset
    localparam logic [31:0] RST_BUS_MGR_ID = 32'h0000_003f;
    localparam logic [31:0] RST_BANDWIDTH  = 32'h0000_1333;
    localparam logic [31:0] RST_CHANNELS   = 32'hffff_ffff;

    // serial-bus addresses of resources and local rom window
    localparam logic [47:0] ADDR_RES_BASE = 48'hffff_f000_021c;
    localparam logic [47:0] ADDR_ROM_LO   = 48'hffff_f000_0400;
    localparam logic [47:0] ADDR_ROM_HI   = 48'hffff_f000_0800;

    typedef enum logic [1:0] {
        SEL_BUS_MGR_ID = 2'b00,
        SEL_BANDWIDTH  = 2'b01,
        SEL_CHAN_HI    = 2'b10,
        SEL_CHAN_LO    = 2'b11
    } resource_sel_t;

    typedef enum logic [1:0] {
        BUS_QUAD_READ = 2'b00,
        BUS_QUAD_LOCK = 2'b01,
        BUS_OTHER     = 2'b10
    } bus_kind_t;

    typedef enum logic [2:0] {
        ACK_COMPLETE    = 3'b000,
        ACK_BUSY        = 3'b001,
        ACK_DATA_ERROR  = 3'b010,
        ACK_MISSING     = 3'b011,
        ACK_OTHER       = 3'b100
    } ack_kind_t;

    typedef enum logic [1:0] {
        TX_REQ       = 2'b00,
        TX_SW_RESP   = 2'b01,
        TX_PHYS_RESP = 2'b10
    } tx_class_t;

endpackage

// ---- swap_if.sv ----
// signals between the register front end and the compare-swap engine.
// assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface swap_if;
    import host_csr_pkg::*;

    logic          host_go;
    resource_sel_t host_sel;
    logic [31:0]   host_cmp;
    logic [31:0]   host_new;
    logic          host_done;
    logic [31:0]   host_old;
    logic          bus_valid;
    bus_kind_t     bus_kind;
    resource_sel_t bus_sel;
    logic [31:0]   bus_cmp;
    logic [31:0]   bus_new;
    logic          bus_resp_valid;
    logic [31:0]   bus_resp_data;
    logic          bus_type_err;

    modport front (output host_go, host_sel, host_cmp, host_new,
                   output bus_valid, bus_kind, bus_sel, bus_cmp, bus_new,
                   input  host_done, host_old, bus_resp_valid, bus_resp_data,
                   input  bus_type_err);
    modport engine (input  host_go, host_sel, host_cmp, host_new,
                    input  bus_valid, bus_kind, bus_sel, bus_cmp, bus_new,
                    output host_done, host_old, bus_resp_valid, bus_resp_data,
                    output bus_type_err);
endinterface

// ---- csr_swap_engine.sv ----
// four bus-management resources with one compare-swap port.
// assumes bus requests arrive one cycle wide; host requests are held here.
`timescale 1ns/100ps
module csr_swap_engine
    import host_csr_pkg::*;
(
    // clock and resets
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic bus_reset,
    // front end
    swap_if.engine    sw
);

    logic [31:0]   res [4];
    logic          host_pend;
    resource_sel_t pend_sel;
    logic [31:0]   pend_cmp;
    logic [31:0]   pend_new;
    logic          bus_lock;
    logic          host_serve;
    logic          bus_ok;

    // anything but a quadlet read or lock is refused, unused codes too
    assign bus_ok     = (sw.bus_kind == BUS_QUAD_READ) || (sw.bus_kind == BUS_QUAD_LOCK);
    assign bus_lock   = sw.bus_valid && (sw.bus_kind == BUS_QUAD_LOCK);
    // bus lock takes the port first; host waits while a bus lock is present, never interleaves
    assign host_serve = host_pend && !bus_lock;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_pend <= 1'b0;
            pend_sel  <= SEL_BUS_MGR_ID;
            pend_cmp  <= 32'h0000_0000;
            pend_new  <= 32'h0000_0000;
        end else begin
            host_pend <= sw.host_go || (host_pend && !host_serve);
            if (sw.host_go) begin
                pend_sel <= sw.host_sel;
                pend_cmp <= sw.host_cmp;
                pend_new <= sw.host_new;
            end
        end
    end

    // resources change only through compare-swap or a system or bus reset
    always_ff @(posedge clk) begin
        if (sys_rst || bus_reset) begin
            res[SEL_BUS_MGR_ID] <= RST_BUS_MGR_ID;
            res[SEL_BANDWIDTH]  <= RST_BANDWIDTH;
            res[SEL_CHAN_HI]    <= RST_CHANNELS;
            res[SEL_CHAN_LO]    <= RST_CHANNELS;
        end else if (bus_lock) begin
            if (res[sw.bus_sel] == sw.bus_cmp)
                res[sw.bus_sel] <= sw.bus_new;
        end else if (host_serve) begin
            if (res[pend_sel] == pend_cmp)
                res[pend_sel] <= pend_new;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw.host_done      <= 1'b0;
            sw.host_old       <= 32'h0000_0000;
            sw.bus_resp_valid <= 1'b0;
            sw.bus_resp_data  <= 32'h0000_0000;
            sw.bus_type_err   <= 1'b0;
        end else begin
            sw.host_done      <= host_serve && !sw.host_go;
            if (host_serve)
                sw.host_old <= res[pend_sel];
            sw.bus_resp_valid <= sw.bus_valid && bus_ok;
            if (sw.bus_valid)
                sw.bus_resp_data <= res[sw.bus_sel];
            sw.bus_type_err   <= sw.bus_valid && !bus_ok;
        end
    end

endmodule

// ---- host_csr_guid_retry_regs.sv ----
// host registers: identity rom read port, retry limits, compare-swap access.
// assumes a single-cycle register port and a same-clock rom and tx engines.
`timescale 1ns/100ps

module host_csr_guid_retry_regs
    import host_csr_pkg::*;
#(
    parameter int ADDR_W = ROM_ADDR_W
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              bus_reset,
    // host register port
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rvalid,
    // identity rom
    output logic                   rom_req,
    output logic      [ADDR_W-1:0] rom_addr,
    input  wire logic              rom_ack,
    input  wire logic [7:0]        rom_data,
    // transmit outcome from the transmit engines
    input  wire logic              tx_done,
    input  wire tx_class_t         tx_class,
    input  wire ack_kind_t         tx_ack,
    output logic                   tx_retry,
    output logic                   tx_report,
    output logic                   phys_dropped,
    // serial-bus requests to local csr space
    input  wire logic              bus_req,
    input  wire logic [47:0]       bus_addr,
    input  wire bus_kind_t         bus_kind,
    input  wire logic [31:0]       bus_cmp,
    input  wire logic [31:0]       bus_new,
    output logic                   bus_rom_hit,
    output logic                   bus_resp_valid,
    output logic      [31:0]       bus_resp_data,
    output logic                   bus_type_err,
    // acknowledge of the generated lock response
    input  wire logic              lock_ack_seen,
    input  wire ack_kind_t         lock_ack,
    output logic                   lock_reply_fail_event
);

    typedef enum logic [1:0] {
        ROM_IDLE  = 2'b00,
        ROM_FETCH = 2'b01
    } rom_state_t;

    swap_if sw ();

    rom_state_t                 rom_state;
    logic                       rom_addr_clear;
    logic                       rom_byte_fetch_go;
    logic [7:0]                 rom_byte_value;
    logic [PHYS_LIM_W-1:0]      phys_resp_retry_limit;
    logic [SMALL_LIM_W-1:0]     sw_resp_retry_limit;
    logic [SMALL_LIM_W-1:0]     req_retry_limit;
    logic [31:0]                swap_value_reg;
    logic [31:0]                expected_value_reg;
    logic                       swap_finished_flag;
    resource_sel_t              resource_selector;
    logic [PHYS_LIM_W-1:0]      tries [3];
    logic                       wr_rom;
    logic                       wr_retry;
    logic                       wr_launch;
    logic                       go_rise;
    logic                       res_hit;
    logic                       can_retry;
    logic [PHYS_LIM_W-1:0]      cur_limit;
    logic [31:0]                next_rdata;

    // serial-bus address decode, used for both resource and rom window checks
    function automatic logic in_range(input logic [47:0] a, input logic [47:0] lo,
                                      input logic [47:0] hi);
        in_range = (a >= lo) && (a < hi);
    endfunction

    assign wr_rom    = reg_wr && (reg_addr == OFF_ROM_PORT);
    assign wr_retry  = reg_wr && (reg_addr == OFF_RETRY);
    assign wr_launch = reg_wr && (reg_addr == OFF_LAUNCH);
    // go is only honoured on a zero-to-one change of the stored bit
    assign go_rise   = wr_rom && reg_wdata[ROM_GO_BIT] && !rom_byte_fetch_go;
    assign res_hit   = in_range(bus_addr, ADDR_RES_BASE, ADDR_RES_BASE + 48'h10)
                       && (bus_addr[1:0] == 2'b00);

    // identity rom read port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rom_addr_clear <= 1'b0;
        end else if (rom_addr_clear && (rom_state == ROM_IDLE)) begin
            // a clear during a fetch waits for it, so the address is really zeroed
            rom_addr_clear <= 1'b0;
        end else if (wr_rom && reg_wdata[ROM_CLR_BIT]) begin
            rom_addr_clear <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rom_state         <= ROM_IDLE;
            rom_byte_fetch_go <= 1'b0;
            rom_req           <= 1'b0;
            rom_addr          <= '0;
            rom_byte_value    <= 8'h00;
        end else begin
            case (rom_state)
                ROM_IDLE: begin
                    // clear only zeroes the address, the data byte stays
                    if (rom_addr_clear)
                        rom_addr <= '0;
                    if (go_rise && !rom_addr_clear) begin
                        rom_byte_fetch_go <= 1'b1;
                        rom_req           <= 1'b1;
                        rom_state         <= ROM_FETCH;
                    end
                end
                ROM_FETCH: begin
                    if (rom_ack) begin
                        rom_byte_value    <= rom_data;
                        rom_byte_fetch_go <= 1'b0;
                        rom_req           <= 1'b0;
                        rom_addr          <= rom_addr + 1'b1;
                        rom_state         <= ROM_IDLE;
                    end
                end
                default: begin
                    rom_state <= ROM_IDLE;
                    rom_req   <= 1'b0;
                end
            endcase
        end
    end

    // retry limits; undefined at reset in the field, zero here for determinism
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phys_resp_retry_limit <= '0;
            sw_resp_retry_limit   <= '0;
            req_retry_limit       <= '0;
        end else if (wr_retry) begin
            phys_resp_retry_limit <= reg_wdata[PHYS_LIM_LSB +: PHYS_LIM_W];
            sw_resp_retry_limit   <= reg_wdata[SWR_LIM_LSB +: SMALL_LIM_W];
            req_retry_limit       <= reg_wdata[REQ_LIM_LSB +: SMALL_LIM_W];
        end
    end

    always_comb begin
        case (tx_class)
            TX_PHYS_RESP: cur_limit = phys_resp_retry_limit;
            TX_SW_RESP:   cur_limit = {1'b0, sw_resp_retry_limit};
            default:      cur_limit = {1'b0, req_retry_limit};
        endcase
    end

    // a zero limit leaves no retry; the first attempt is not counted
    assign can_retry = ((tx_ack == ACK_BUSY) || (tx_ack == ACK_DATA_ERROR))
                       && (tries[tx_class] < cur_limit);

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_tries
            always_ff @(posedge clk) begin
                if (sys_rst)
                    tries[g] <= '0;
                else if (tx_done && (tx_class == g))
                    tries[g] <= can_retry ? tries[g] + 1'b1 : '0;
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_retry     <= 1'b0;
            tx_report    <= 1'b0;
            phys_dropped <= 1'b0;
        end else begin
            tx_retry     <= tx_done && can_retry;
            // physical responses end without telling software
            tx_report    <= tx_done && !can_retry && (tx_class != TX_PHYS_RESP);
            phys_dropped <= tx_done && !can_retry && (tx_class == TX_PHYS_RESP)
                            && (tx_ack != ACK_COMPLETE);
        end
    end

    // host compare-swap registers; software orders the three writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            swap_value_reg     <= 32'h0000_0000;
            expected_value_reg <= 32'h0000_0000;
            resource_selector  <= SEL_BUS_MGR_ID;
        end else begin
            if (sw.host_done)
                swap_value_reg <= sw.host_old;
            else if (reg_wr && (reg_addr == OFF_SWAP_VALUE))
                swap_value_reg <= reg_wdata;
            if (reg_wr && (reg_addr == OFF_EXPECTED))
                expected_value_reg <= reg_wdata;
            if (wr_launch)
                resource_selector <= resource_sel_t'(reg_wdata[SEL_W-1:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            swap_finished_flag <= 1'b1;
        else if (sw.host_done)
            swap_finished_flag <= 1'b1;
        else if (wr_launch)
            swap_finished_flag <= 1'b0;
    end

    // launch and bus requests toward the engine, registered one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw.host_go   <= 1'b0;
            sw.host_sel  <= SEL_BUS_MGR_ID;
            sw.host_cmp  <= 32'h0000_0000;
            sw.host_new  <= 32'h0000_0000;
            sw.bus_valid <= 1'b0;
            sw.bus_kind  <= BUS_QUAD_READ;
            sw.bus_sel   <= SEL_BUS_MGR_ID;
            sw.bus_cmp   <= 32'h0000_0000;
            sw.bus_new   <= 32'h0000_0000;
        end else begin
            sw.host_go   <= wr_launch;
            sw.host_sel  <= resource_sel_t'(reg_wdata[SEL_W-1:0]);
            sw.host_cmp  <= expected_value_reg;
            sw.host_new  <= swap_value_reg;
            sw.bus_valid <= bus_req && res_hit;
            sw.bus_kind  <= bus_kind;
            sw.bus_sel   <= resource_sel_t'(bus_addr[3:2] - ADDR_RES_BASE[3:2]);
            sw.bus_cmp   <= bus_cmp;
            sw.bus_new   <= bus_new;
        end
    end

    csr_swap_engine u_engine (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .bus_reset (bus_reset),
        .sw        (sw.engine)
    );

    assign bus_resp_valid = sw.bus_resp_valid;
    assign bus_resp_data  = sw.bus_resp_data;
    assign bus_type_err   = sw.bus_type_err;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rom_hit           <= 1'b0;
            lock_reply_fail_event <= 1'b0;
        end else begin
            bus_rom_hit           <= bus_req && in_range(bus_addr, ADDR_ROM_LO,
                                                         ADDR_ROM_HI);
            lock_reply_fail_event <= lock_ack_seen && (lock_ack != ACK_COMPLETE);
        end
    end

    // register read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            OFF_ROM_PORT: begin
                next_rdata[ROM_CLR_BIT] = rom_addr_clear;
                next_rdata[ROM_GO_BIT]  = rom_byte_fetch_go;
                next_rdata[ROM_DATA_LSB +: 8] = rom_byte_value;
            end
            OFF_RETRY: begin
                // seconds and cycles fields stay zero
                next_rdata[PHYS_LIM_LSB +: PHYS_LIM_W] = phys_resp_retry_limit;
                next_rdata[SWR_LIM_LSB +: SMALL_LIM_W] = sw_resp_retry_limit;
                next_rdata[REQ_LIM_LSB +: SMALL_LIM_W] = req_retry_limit;
            end
            OFF_SWAP_VALUE: next_rdata = swap_value_reg;
            OFF_EXPECTED:   next_rdata = expected_value_reg;
            OFF_LAUNCH: begin
                next_rdata[DONE_BIT]    = swap_finished_flag;
                next_rdata[SEL_W-1:0]   = resource_selector;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata  <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

endmodule

// ---- host_csr_monitor.sv ----
// port assertions for the host csr block.
// assumes it is bound into host_csr_guid_retry_regs.
`timescale 1ns/100ps
module host_csr_monitor
    import host_csr_pkg::*;
#(
    parameter int ADDR_W = ROM_ADDR_W
)
(
    // clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // rom and transmit outcome
    input wire logic              rom_req,
    input wire logic [ADDR_W-1:0] rom_addr,
    input wire logic              rom_ack,
    input wire logic              tx_done,
    input wire tx_class_t         tx_class,
    input wire ack_kind_t         tx_ack,
    input wire logic              tx_retry,
    input wire logic              tx_report,
    input wire logic              phys_dropped,
    // serial bus
    input wire logic              bus_req,
    input wire logic [47:0]       bus_addr,
    input wire bus_kind_t         bus_kind,
    input wire logic              bus_rom_hit,
    input wire logic              bus_type_err,
    input wire logic              lock_ack_seen,
    input wire ack_kind_t         lock_ack,
    input wire logic              lock_reply_fail_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_fetch_step;
        rom_req && rom_ack |=> !rom_req && rom_addr == $past(rom_addr) + 1'b1;
    endproperty
    a_fetch_step: assert property (p_fetch_step) else $error("rom fetch end wrong");
    property p_req_hold;
        rom_req && !rom_ack |=> rom_req && $stable(rom_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("rom fetch dropped");
    property p_retry_cause;
        tx_retry |-> $past(tx_done) && $past(tx_ack) inside {ACK_BUSY, ACK_DATA_ERROR};
    endproperty
    a_retry_cause: assert property (p_retry_cause) else $error("retry without cause");
    property p_missing_none;
        tx_done && tx_ack == ACK_MISSING |=> !tx_retry;
    endproperty
    a_missing_none: assert property (p_missing_none) else $error("retry on missing");
    property p_phys_quiet;
        tx_done && tx_class == TX_PHYS_RESP |=> !tx_report;
    endproperty
    a_phys_quiet: assert property (p_phys_quiet) else $error("phys outcome reported");
    property p_drop_cause;
        phys_dropped |-> $past(tx_done) && $past(tx_class) == TX_PHYS_RESP;
    endproperty
    a_drop_cause: assert property (p_drop_cause) else $error("drop without phys");
    property p_rom_hit;
        bus_req && bus_addr >= ADDR_ROM_LO && bus_addr < ADDR_ROM_HI |=> bus_rom_hit;
    endproperty
    a_rom_hit: assert property (p_rom_hit) else $error("rom window missed");
    property p_type_err;
        bus_req && bus_kind == BUS_OTHER && bus_addr == ADDR_RES_BASE |-> ##2 bus_type_err;
    endproperty
    a_type_err: assert property (p_type_err) else $error("type error missing");
    property p_lock_fail;
        lock_ack_seen |=> lock_reply_fail_event == ($past(lock_ack) != ACK_COMPLETE);
    endproperty
    a_lock_fail: assert property (p_lock_fail) else $error("lock event wrong");

    c_fetch: cover property (rom_req && rom_ack);
    c_retry: cover property (tx_retry);
    c_lock_fail: cover property (lock_reply_fail_event);
endmodule

bind host_csr_guid_retry_regs host_csr_monitor #(.ADDR_W(ADDR_W)) mon (.*);

// ---- rom_model.sv ----
// identity rom model: answers a held fetch after 1..4 cycles.
// assumes rom_req stays up until rom_ack.
`timescale 1ns/100ps
module rom_model (
    // clock
    input  wire logic       clk,
    // fetch port
    input  wire logic       rom_req,
    input  wire logic [7:0] rom_addr,
    output logic            rom_ack,
    output logic [7:0]      rom_data
);
    int cnt = 0;
    initial begin
        rom_ack = 1'b0;
        rom_data = 8'h00;
    end
    always @(posedge clk) begin
        #1;
        rom_ack = 1'b0;
        // stale byte would hide a late capture
        rom_data = ~rom_data;
        if (!rom_req) begin
            cnt = 0;
        end else if (cnt == int'(rom_addr[1:0])) begin
            rom_ack = 1'b1;
            rom_data = (rom_addr * 8'h1d) ^ 8'ha5;
            cnt = 0;
        end else begin
            cnt++;
        end
    end
endmodule

// ---- host_csr_guid_retry_regs_test.sv ----
// self-checking bench for the host csr block with an identity rom model.
// assumes default parameters.
`timescale 1ns/100ps
module host_csr_guid_retry_regs_test;
    import host_csr_pkg::*;
    logic        clk, sys_rst, bus_reset, reg_wr, reg_rd, reg_rvalid, rom_req, rom_ack;
    logic        tx_done, tx_retry, tx_report, phys_dropped, bus_req, bus_rom_hit;
    logic        bus_resp_valid, bus_type_err, lock_ack_seen, lock_reply_fail_event;
    logic [7:0]  reg_addr, rom_addr, rom_data;
    logic [31:0] reg_wdata, reg_rdata, bus_cmp, bus_new, bus_resp_data, rd_val, cmp, nw;
    logic [47:0] bus_addr;
    tx_class_t   tx_class;
    ack_kind_t   tx_ack, lock_ack;
    bus_kind_t   bus_kind;
    logic [31:0] res [4];
    int          n_mismatch = 0, checks_done = 0, seed = 32'h4945497b, k, w, i;
    int          lim [3];

    host_csr_guid_retry_regs uut (.*);
    rom_model rom (.*);

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] rom_byte(input int a);
        return (a[7:0] * 8'h1d) ^ 8'ha5;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(posedge clk); #1;
        {reg_wr, reg_rd} = 2'b00;
        rd_val = reg_rdata;
        check(reg_rvalid, !wr);
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        w = 0;
        do begin
            reg_op(0, a, 0);
            w++;
        end while (rd_val[b] !== v && w < 30);
    endtask
    task automatic bus(input bus_kind_t kd, input int s, input logic [31:0] c, n);
        @(posedge clk); #1;
        {bus_req, bus_addr, bus_cmp, bus_new} = {1'b1, ADDR_RES_BASE + 4 * s, c, n};
        bus_kind = kd;
        @(posedge clk); #1;
        bus_req = 0;
        @(posedge clk); #1;
    endtask
    task automatic tx(input tx_class_t c, input ack_kind_t a);
        @(posedge clk); #1;
        tx_done = 1'b1;
        tx_class = c;
        tx_ack = a;
        @(posedge clk); #1;
        tx_done = 0;
    endtask
    task automatic bus_all;
        for (k = 0; k < 4; k++) begin
            bus(BUS_QUAD_READ, k, 0, 0);
            check(bus_resp_data, res[k]);
        end
    endtask
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        results();
    end

    initial begin
        {bus_reset, reg_wr, reg_rd, reg_addr, reg_wdata, tx_done, bus_req, lock_ack_seen} = 0;
        {bus_addr, bus_cmp, bus_new} = 0;
        tx_class = TX_REQ;
        tx_ack = ACK_COMPLETE;
        lock_ack = ACK_COMPLETE;
        bus_kind = BUS_QUAD_READ;
        res = '{RST_BUS_MGR_ID, RST_BANDWIDTH, RST_CHANNELS, RST_CHANNELS};
        sys_rst = 1;
        repeat (20) @(posedge clk);
        #1 sys_rst = 0;
        reg_op(0, OFF_LAUNCH, 0);
        check(rd_val[DONE_BIT], 1);
        reg_op(0, 8'h00, 0);
        check(rd_val, 0);
        // rom: clear, three fetches, clear keeps last byte
        reg_op(1, OFF_ROM_PORT, 32'h8000_0000);
        poll(OFF_ROM_PORT, ROM_CLR_BIT, 0);
        check(rom_addr, 0);
        for (i = 0; i < 3; i++) begin
            reg_op(1, OFF_ROM_PORT, 32'h0200_0000);
            poll(OFF_ROM_PORT, ROM_GO_BIT, 0);
            check(rd_val[23:16], rom_byte(i));
            check(rom_addr, i + 1);
        end
        reg_op(1, OFF_ROM_PORT, 32'h8000_0000);
        poll(OFF_ROM_PORT, ROM_CLR_BIT, 0);
        check(rd_val[23:16], rom_byte(2));
        check(rom_addr, 0);
        $display("rom test done");
        // retry limits; request limit zero is the corner
        lim = '{0, ($random(seed) & 3) + 1, ($random(seed) & 7) + 1};
        reg_op(1, OFF_RETRY, {16'hffff, lim[2][4:0], 3'h7, lim[1][3:0], lim[0][3:0]});
        reg_op(0, OFF_RETRY, 0);
        check(rd_val, {16'h0, lim[2][4:0], 3'h0, lim[1][3:0], lim[0][3:0]});
        for (k = 0; k < 3; k++) begin
            for (i = 0; i <= lim[k]; i++) begin
                tx(tx_class_t'(k), i[0] ? ACK_DATA_ERROR : ACK_BUSY);
                check(tx_retry, i < lim[k]);
            end
            check(tx_report, k != 2);
            check(phys_dropped, k == 2);
            tx(tx_class_t'(k), ACK_MISSING);
            check(tx_retry, 0);
            check(phys_dropped, k == 2);
            tx(tx_class_t'(k), ACK_COMPLETE);
            check(tx_retry, 0);
            check(phys_dropped, 0);
        end
        $display("retry test done");
        // host compare-swap on every selector, half with a matching compare
        for (i = 0; i < 8; i++) begin
            nw = $random(seed);
            cmp = i[2] ? res[i % 4] : $random(seed);
            reg_op(1, OFF_SWAP_VALUE, nw);
            reg_op(1, OFF_EXPECTED, cmp);
            reg_op(1, OFF_LAUNCH, i % 4);
            poll(OFF_LAUNCH, DONE_BIT, 1);
            check(rd_val[DONE_BIT], 1);
            reg_op(0, OFF_SWAP_VALUE, 0);
            check(rd_val, res[i % 4]);
            if (res[i % 4] === cmp) res[i % 4] = nw;
        end
        bus_all();
        // bus locks, type error, lock acknowledge outcomes
        for (i = 0; i < 4; i++) begin
            nw = $random(seed);
            cmp = i[0] ? 32'h0 : res[i];
            bus(BUS_QUAD_LOCK, i, cmp, nw);
            check(bus_resp_valid, 1);
            check(bus_resp_data, res[i]);
            if (res[i] === cmp) res[i] = nw;
        end
        bus_all();
        bus(BUS_OTHER, 0, 0, 0);
        check(bus_type_err, 1);
        check(bus_resp_valid, 0);
        for (i = 0; i < 5; i++) begin
            @(posedge clk); #1;
            lock_ack_seen = 1'b1;
            lock_ack = ack_kind_t'(i);
            @(posedge clk); #1;
            lock_ack_seen = 0;
            check(lock_reply_fail_event, i != 0);
        end
        @(posedge clk); #1;
        {bus_req, bus_addr} = {1'b1, ADDR_ROM_LO + 48'h10};
        bus_kind = BUS_QUAD_READ;
        @(posedge clk); #1;
        bus_req = 0;
        check(bus_rom_hit, 1);
        $display("swap test done");
        bus_reset = 1;
        @(posedge clk); #1;
        bus_reset = 0;
        res = '{RST_BUS_MGR_ID, RST_BANDWIDTH, RST_CHANNELS, RST_CHANNELS};
        bus_all();
        $display("bus reset test done");
        results();
    end
endmodule
